//--- logic/rar_remapper.sv
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Purpose: i2c pass-through address remapping toward the remote side
// Assumes: rx_lock and back-channel inputs are asynchronous pins
// Notes: one request is looked up per cycle, answer one cycle later
// Operation
// R1: zero deserializer physical id blocks access to remote deserializer.
// R2: after receiver lock, load deserializer id from control channel.
// R3: hold bit set stops auto-load and keeps software value.
// R4: deserializer alias match is replaced by deserializer physical id; zero alias disables.
// R5: slave alias match is replaced by remote slave physical address.
// R6: zero remote slave physical address disables slave access.
// R7: ten-bit select changes payload mode only while override is set.
// R8: software clears twelve-bit select when setting ten-bit select.
// R9: override makes local mode bits win over back-channel mode bits.
// R10: slave alias field in bits 7:1 configures the slave decoder.
// R11: addresses matching no enabled alias are neither remapped nor forwarded.
module rar_remapper (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic rx_lock,
  input wire logic [6:0] bc_deser_id,
  input wire logic [1:0] bc_mode,
  input wire logic req_valid,
  input wire logic [6:0] req_addr,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic fwd_to_slave,
  output logic req_local,
  output logic ten_bit_mode,
  output logic twelve_bit_mode
);
  logic [7:0] mode_select;
  logic [7:0] deser_id;
  logic [7:0] deser_alias;
  logic [7:0] remote_target_phys_addr;
  logic [7:0] slave_alias;
  logic lock_s1, lock_s2;
  logic [6:0] bcid_s1, bcid_s2, bcid_s3;
  logic [1:0] bcm_s1, bcm_s2;
  logic [1:0] next_mode;
  rar_match_if mi ();

  assign mi.req_addr = req_addr;
  assign mi.deser_alias = deser_alias[7:1];
  assign mi.deser_phys = deser_id[7:1];
  assign mi.slave_alias = slave_alias[7:1];
  assign mi.slave_phys = remote_target_phys_addr[7:1];

  rar_matcher u_match (
    .m(mi.matcher)
  );

  // pins pass two flops; a third id copy only feeds the stability compare
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      bcid_s1 <= 7'h00;
      bcid_s2 <= 7'h00;
      bcid_s3 <= 7'h00;
      bcm_s1 <= 2'h0;
      bcm_s2 <= 2'h0;
    end else begin
      lock_s1 <= rx_lock;
      lock_s2 <= lock_s1;
      bcid_s1 <= bc_deser_id;
      bcid_s2 <= bcid_s1;
      bcid_s3 <= bcid_s2;
      bcm_s1 <= bc_mode;
      bcm_s2 <= bcm_s1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_select <= rar_pkg::RESET_MODE_SELECT;
      deser_alias <= rar_pkg::RESET_ID;
      remote_target_phys_addr <= rar_pkg::RESET_ID;
      slave_alias <= rar_pkg::RESET_ID;
    end else if (reg_write) begin
      case (reg_addr)
        rar_pkg::ADDR_MODE_SELECT: mode_select <= reg_wdata;
        rar_pkg::ADDR_DESER_ALIAS: deser_alias <= reg_wdata;
        rar_pkg::ADDR_REMOTE_TARGET_PHYS_ADDR: remote_target_phys_addr <= reg_wdata;
        rar_pkg::ADDR_SLAVE_ALIAS: slave_alias <= reg_wdata; // [R10]
        default: mode_select <= mode_select;
      endcase
    end
  end

  // a software write wins over a same-cycle auto-load
  // an id word still settling across the pins is skipped, never loaded half-changed
  always_ff @(posedge clk) begin
    if (reset) begin
      deser_id <= rar_pkg::RESET_ID;
    end else if (reg_write && reg_addr == rar_pkg::ADDR_DESER_ID) begin
      deser_id <= reg_wdata;
    end else if (lock_s2 && bcid_s2 == bcid_s3 && !deser_id[rar_pkg::HOLD_ID_POS]) begin // [R2] [R3]
      deser_id <= {bcid_s2, 1'b0};
    end
  end

  always_comb begin
    if (mode_select[rar_pkg::MODE_OVERRIDE_POS]) begin // [R9] [R7]
      next_mode = {mode_select[rar_pkg::MODE_TWELVE_BIT_POS], mode_select[rar_pkg::MODE_TEN_BIT_POS]};
    end else begin
      next_mode = bcm_s2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ten_bit_mode <= 1'b0;
      twelve_bit_mode <= 1'b0;
    end else begin
      ten_bit_mode <= next_mode[0]; // [R7]
      twelve_bit_mode <= next_mode[1];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_valid <= 1'b0;
      fwd_addr <= 7'h00;
      fwd_to_slave <= 1'b0;
      req_local <= 1'b0;
    end else begin
      fwd_valid <= req_valid && mi.route != rar_pkg::RAR_ROUTE_NONE; // [R11]
      fwd_addr <= mi.route != rar_pkg::RAR_ROUTE_NONE ? mi.mapped_addr : 7'h00;
      fwd_to_slave <= req_valid && mi.route == rar_pkg::RAR_ROUTE_SLAVE; // [R5]
      req_local <= req_valid && mi.route == rar_pkg::RAR_ROUTE_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        rar_pkg::ADDR_MODE_SELECT: reg_rdata <= {mode_select[7:4], twelve_bit_mode, ten_bit_mode,
          mode_select[1:0]};
        rar_pkg::ADDR_DESER_ID: reg_rdata <= deser_id;
        rar_pkg::ADDR_DESER_ALIAS: reg_rdata <= deser_alias;
        rar_pkg::ADDR_REMOTE_TARGET_PHYS_ADDR: reg_rdata <= remote_target_phys_addr;
        rar_pkg::ADDR_SLAVE_ALIAS: reg_rdata <= slave_alias;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // lookup answers stand exactly one cycle after their request
  deser_block_a: assert property ( // [R1]
    req_valid && deser_id[7:1] == 7'h00 && slave_alias[7:1] != req_addr |=> !fwd_valid)
    else $error("zero deserializer id forwarded");
  deser_map_a: assert property ( // [R4]
    req_valid && req_addr == deser_alias[7:1] && deser_alias[7:1] != 7'h00 && deser_id[7:1] != 7'h00
    |=> fwd_valid && fwd_addr == $past(deser_id[7:1]) && !fwd_to_slave)
    else $error("deserializer alias not remapped");
  deser_alias_off_a: assert property ( // [R4]
    req_valid && deser_alias[7:1] == 7'h00 && req_addr != slave_alias[7:1] |=> !fwd_valid)
    else $error("zero deserializer alias forwarded");
  slave_map_a: assert property ( // [R5]
    req_valid && req_addr == slave_alias[7:1] && req_addr != deser_alias[7:1]
    && slave_alias[7:1] != 7'h00 && remote_target_phys_addr[7:1] != 7'h00
    |=> fwd_to_slave && fwd_addr == $past(remote_target_phys_addr[7:1]))
    else $error("slave alias not remapped");
  slave_route_a: assert property ( // [R5]
    fwd_to_slave |-> fwd_valid)
    else $error("slave forward without valid");
  slave_block_a: assert property ( // [R6]
    remote_target_phys_addr[7:1] == 7'h00 |=> !fwd_to_slave)
    else $error("zero remote_target_phys_addr forwarded");
  slave_alias_off_a: assert property ( // [R10]
    req_valid && slave_alias[7:1] == 7'h00 && req_addr != deser_alias[7:1] |=> !fwd_valid)
    else $error("zero slave alias forwarded");
  no_match_a: assert property ( // [R11]
    req_valid && req_addr != deser_alias[7:1] && req_addr != slave_alias[7:1]
    |=> !fwd_valid && req_local)
    else $error("unmatched address forwarded");
  one_answer_a: assert property ( // [R11]
    !(fwd_valid && req_local))
    else $error("request both forwarded and local");
  idle_quiet_a: assert property ( // [R11]
    !req_valid |=> !fwd_valid && !fwd_to_slave && !req_local)
    else $error("answer without request");

  // deserializer id: auto-load, freeze and software access
  auto_load_a: assert property ( // [R2]
    lock_s2 && bcid_s2 == bcid_s3 && !deser_id[rar_pkg::HOLD_ID_POS] && !reg_write
    |=> deser_id == {$past(bcid_s2), 1'b0})
    else $error("id not auto-loaded");
  no_lock_a: assert property ( // [R2]
    !lock_s2 && !(reg_write && reg_addr == rar_pkg::ADDR_DESER_ID)
    |=> $stable(deser_id))
    else $error("id changed without lock");
  id_read_a: assert property ( // [R2]
    reg_read && reg_addr == rar_pkg::ADDR_DESER_ID |=> reg_rdata == $past(deser_id))
    else $error("deserializer id read wrong");
  hold_id_a: assert property ( // [R3]
    deser_id[rar_pkg::HOLD_ID_POS] && !(reg_write && reg_addr == rar_pkg::ADDR_DESER_ID)
    |=> $stable(deser_id))
    else $error("held id changed");
  hold_write_a: assert property ( // [R3]
    reg_write && reg_addr == rar_pkg::ADDR_DESER_ID |=> deser_id == $past(reg_wdata))
    else $error("software id not kept");

  // payload mode: override picks the local bits, else the back channel
  override_mode_a: assert property ( // [R7]
    mode_select[rar_pkg::MODE_OVERRIDE_POS]
    |=> ten_bit_mode == $past(mode_select[rar_pkg::MODE_TEN_BIT_POS]))
    else $error("override ten-bit ignored");
  twelve_override_a: assert property ( // [R7]
    mode_select[rar_pkg::MODE_OVERRIDE_POS]
    |=> twelve_bit_mode == $past(mode_select[rar_pkg::MODE_TWELVE_BIT_POS]))
    else $error("override twelve-bit ignored");
  backchan_mode_a: assert property ( // [R9]
    !mode_select[rar_pkg::MODE_OVERRIDE_POS] |=> twelve_bit_mode == $past(bcm_s2[1]))
    else $error("back-channel mode ignored");
  ten_backchan_a: assert property ( // [R9]
    !mode_select[rar_pkg::MODE_OVERRIDE_POS] |=> ten_bit_mode == $past(bcm_s2[0]))
    else $error("back-channel ten-bit ignored");

  // alias registers read back as written
  alias_read_a: assert property ( // [R4]
    reg_read && reg_addr == rar_pkg::ADDR_DESER_ALIAS |=> reg_rdata == $past(deser_alias))
    else $error("deserializer alias read wrong");
  slave_alias_read_a: assert property ( // [R10]
    reg_read && reg_addr == rar_pkg::ADDR_SLAVE_ALIAS |=> reg_rdata == $past(slave_alias))
    else $error("slave alias read wrong");

  deser_fwd_c: cover property (req_valid ##1 fwd_valid && !fwd_to_slave);
  slave_fwd_c: cover property (req_valid ##1 fwd_to_slave);
  // load lands one edge after the third id copy agrees
  auto_load_c: cover property ($rose(lock_s2) ##2 deser_id != 8'h00);
  override_c: cover property (mode_select[rar_pkg::MODE_OVERRIDE_POS] && ten_bit_mode);
  backchan_c: cover property (!mode_select[rar_pkg::MODE_OVERRIDE_POS] && twelve_bit_mode);
endmodule // rar_remapper

//--- logic/rar_pkg.sv
// Purpose: shared constants for the remote address remapper
// Assumes: 8-bit register port, byte offsets as printed
// Notes: alias and physical id fields sit in bits 7:1
package rar_pkg;
  localparam logic [7:0] ADDR_MODE_SELECT = 8'h05;
  localparam logic [7:0] ADDR_DESER_ID = 8'h06;
  localparam logic [7:0] ADDR_DESER_ALIAS = 8'h07;
  localparam logic [7:0] ADDR_REMOTE_TARGET_PHYS_ADDR = 8'h08;
  localparam logic [7:0] ADDR_SLAVE_ALIAS = 8'h09;
  localparam int MODE_TEN_BIT_POS = 0;
  localparam int MODE_TWELVE_BIT_POS = 1;
  localparam int MODE_OVERRIDE_POS = 5;
  localparam int HOLD_ID_POS = 0;
  localparam logic [7:0] RESET_MODE_SELECT = 8'h00;
  localparam logic [7:0] RESET_ID = 8'h00;
  localparam logic [6:0] ADDR_NONE = 7'h00;
  typedef enum logic [1:0] {RAR_ROUTE_NONE, RAR_ROUTE_DESER, RAR_ROUTE_SLAVE} rar_route_t;
endpackage

//--- logic/rar_match_if.sv
`timescale 1ns/1ps
// Purpose: carries alias table and lookup between the top and the matcher
// Assumes: single clock domain
// Notes: purely combinational signals
interface rar_match_if;
  logic [6:0] req_addr;
  logic [6:0] deser_alias;
  logic [6:0] deser_phys;
  logic [6:0] slave_alias;
  logic [6:0] slave_phys;
  rar_pkg::rar_route_t route;
  logic [6:0] mapped_addr;
  modport top (output req_addr, output deser_alias, output deser_phys, output slave_alias,
    output slave_phys, input route, input mapped_addr);
  modport matcher (input req_addr, input deser_alias, input deser_phys, input slave_alias,
    input slave_phys, output route, output mapped_addr);
endinterface

//--- logic/rar_matcher.sv
`timescale 1ns/1ps
// Purpose: compares a request address with both aliases
// Assumes: zero alias or zero physical id disables a path
// Notes: deserializer path wins if both aliases are equal
module rar_matcher (
  rar_match_if.matcher m
);
  always_comb begin
    m.route = rar_pkg::RAR_ROUTE_NONE; // [R11]
    m.mapped_addr = m.req_addr;
    if (m.deser_alias != rar_pkg::ADDR_NONE && m.deser_phys != rar_pkg::ADDR_NONE &&
        m.req_addr == m.deser_alias) begin // [R1] [R4]
      m.route = rar_pkg::RAR_ROUTE_DESER;
      m.mapped_addr = m.deser_phys; // [R4]
    end else if (m.slave_alias != rar_pkg::ADDR_NONE && m.slave_phys != rar_pkg::ADDR_NONE &&
        m.req_addr == m.slave_alias) begin // [R6] [R10]
      m.route = rar_pkg::RAR_ROUTE_SLAVE;
      m.mapped_addr = m.slave_phys; // [R5]
    end
  end
endmodule // rar_matcher

//--- tb/rar_far_model.sv
// Purpose: remote deserializer side feeding lock, id and mode to the remapper
// Assumes: values launched right after a rising edge
// Notes: id churns while unlocked so a stale value is never seen as stable
`timescale 1ns/1ps
module rar_far_model (
  input wire logic clk,
  input wire logic up,
  input wire logic [6:0] id,
  input wire logic [1:0] mode,
  output logic rx_lock,
  output logic [6:0] bc_deser_id,
  output logic [1:0] bc_mode
);
  initial bc_deser_id = 7'h55;
  always @(posedge clk) begin
    rx_lock <= up;
    bc_deser_id <= up ? id : ~bc_deser_id;
    bc_mode <= mode;
  end
endmodule // rar_far_model

//--- tb/remote_i2c_address_remapper_test.sv
// Purpose: self-checking bench for the remote address remapper
// Assumes: 25 MHz clock, synchronous reset
// Notes: aliases kept distinct so only one path can match
`timescale 1ns/1ps
module remote_i2c_address_remapper_test;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0, req_valid = 0, up = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0] req_addr = 7'h00, id = 7'h00, da, dp, sa, sp, fwd_addr, bc_deser_id;
  logic [1:0] mode = 2'h0, bc_mode;
  logic rx_lock, fwd_valid, fwd_to_slave, req_local, ten_bit_mode, twelve_bit_mode;
  logic [31:0] s = 32'hfaa89f17, r;
  int fails = 0, samples_checked = 0, cyc = 0;
  rar_far_model rar_far_model_i (.clk(clk), .up(up), .id(id), .mode(mode), .rx_lock(rx_lock),
    .bc_deser_id(bc_deser_id), .bc_mode(bc_mode));
  rar_remapper rar_remapper_i (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_lock(rx_lock),
    .bc_deser_id(bc_deser_id), .bc_mode(bc_mode), .req_valid(req_valid), .req_addr(req_addr),
    .fwd_valid(fwd_valid), .fwd_addr(fwd_addr), .fwd_to_slave(fwd_to_slave), .req_local(req_local),
    .ten_bit_mode(ten_bit_mode), .twelve_bit_mode(twelve_bit_mode));
  initial forever #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // {valid, to_slave, local, addr}
  function automatic logic [9:0] ex(input logic [6:0] a);
    if (da != 7'h00 && dp != 7'h00 && a == da) return {3'b100, dp};
    if (sa != 7'h00 && sp != 7'h00 && a == sa) return {3'b110, sp};
    return 10'h080;
  endfunction
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk) reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk) reg_read <= 1'b0;
    #1 chk({2'h0, reg_rdata}, {2'h0, e});
  endtask
  task automatic lk(input logic [6:0] a);
    @(posedge clk) {req_addr, req_valid} <= {a, 1'b1};
    @(posedge clk) req_valid <= 1'b0;
    #1 chk({fwd_valid, fwd_to_slave, req_local, fwd_addr}, ex(a));
  endtask
  task automatic cfg();
    wr(8'h06, {dp, 1'b1});
    wr(8'h07, {da, 1'b0});
    wr(8'h08, {sp, 1'b0});
    wr(8'h09, {sa, 1'b0});
  endtask
  task automatic mchk(input logic [1:0] e);
    repeat (6) @(posedge clk);
    #1 chk({8'h00, twelve_bit_mode, ten_bit_mode}, {8'h00, e});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int a = 6; a < 10; a++) rd(8'(a), 8'h00); // reset values
    rd(8'h20, 8'h00); // unmapped address reads zero
    id <= 7'h2b;
    up <= 1'b1;
    rd(8'h06, 8'h00);
    repeat (5) @(posedge clk);
    rd(8'h06, 8'h56);
    wr(8'h06, 8'h63);
    id <= 7'h11;
    repeat (5) @(posedge clk);
    rd(8'h06, 8'h63);
    for (int i = 0; i < 10; i++) begin
      r = rnd();
      {da, dp, sa, sp} = r[27:0];
      if (sa == da) sa = da ^ 7'h01;
      if (i == 8) dp = 7'h00;
      if (i == 9) begin
        sp = 7'h00;
        da = 7'h00;
      end
      cfg();
      rd(8'h07, {da, 1'b0});
      lk(da);
      lk(sa);
      lk(da ^ 7'h40);
      r = rnd();
      lk(r[6:0]);
    end
    mode <= 2'b01;
    mchk(2'b01);
    wr(8'h05, 8'h22);
    mchk(2'b10);
    rd(8'h05, 8'h2a);
    wr(8'h05, 8'h21);
    mchk(2'b01);
    mode <= 2'b10;
    wr(8'h05, 8'h01);
    mchk(2'b10);
    // mid-run reset clears the freeze, so the locked link reloads the id
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h09, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h06, 8'h22);
    conclude();
  end
endmodule // remote_i2c_address_remapper_test
